// ---- hw/sbr_cfg.svh ----
// Register offsets, field positions, reset values and write masks of the backlight port
`ifndef SBR_CFG_SVH
`define SBR_CFG_SVH
`define SBR_ADDR_CLASS      4'h5
`define SBR_ADDR_BIT3       3
`define SBR_ADDR_WR         8'h58
`define SBR_ADDR_RD         8'h59
`define SBR_OFS_PWM         8'h00
`define SBR_OFS_CTRL        8'h01
`define SBR_OFS_FAULT       8'h02
`define SBR_OFS_ID          8'h03
`define SBR_OFS_DC          8'h07
`define SBR_OFS_CFG         8'h08
`define SBR_OFS_MASK        8'h09
`define SBR_RST_PWM         8'hFF
`define SBR_RST_CTRL        8'h00
`define SBR_RST_DC          8'hFF
`define SBR_RST_CFG         8'h03
`define SBR_RST_MASK        8'hFF
`define SBR_ID_VALUE        8'hA5 // Arbitrary neutral identity value
`define SBR_CTRL_MASK       8'h07
`define SBR_CFG_MASK        8'h07
`define SBR_BIT_BL_ON       0
`define SBR_BIT_SRC_SEL     1
`define SBR_BIT_UPD_STYLE   2
`endif

// ---- hw/sbr_pkg.sv ----
// Types shared by the backlight register port
package sbr_pkg;
   typedef enum logic [1:0] {
      SBR_DIM_BUS,
      SBR_DIM_EXT,
      SBR_DIM_COMBINED
   } sbr_dim_mode_t;

   typedef struct packed {
      logic two_channels_off;
      logic one_channel_off;
      logic input_overcurrent;
      logic thermal_trip;
   } sbr_faults_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } sbr_wr_t;
endpackage

// ---- hw/sbr_sync.sv ----
// Two-flop synchroniser for levels and toggles
`timescale 1ns/100ps
`default_nettype none
module sbr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             CLK,
   input  wire logic             SRST,
   input  wire logic [WIDTH-1:0] D,
   output var  logic [WIDTH-1:0] Q
);
   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge CLK) begin
      if (SRST) begin
         meta_r <= '0;
         Q      <= '0;
      end else begin
         meta_r <= D;
         Q      <= meta_r;
      end
   end
endmodule // sbr_sync
`default_nettype wire

// ---- hw/sbr_port.sv ----
// SMBus byte register bank of the backlight controller
`timescale 1ns/100ps
`default_nettype none
`include "sbr_cfg.svh"

// Summary of operation
// - Write takes address with write bit, command code, then data stored there.
// - Read takes address, command, repeated address with bit 0 set, returns byte.
// - Read returns current content of register indexed by earlier command code.
// - Device drives data line only for acknowledges and returned data bits.
// - Respond only when address upper nibble equals binary 0101.
// - Bit 3 of matched address byte must be one.
// - Address bit 0 gives direction; 0x58 writes, 0x59 reads.
// - Registers are eight bits, reached only through byte transactions.
// - Reserved bits hold zero and read back zero.
// - Update-style bit selects absolute or percentage brightness, resets zero.
// - Source select bit picks external input or bus registers, resets zero.
// - Backlight-on bit switches backlight on or off, resets off.
// - Status reports shutdowns, backlight state, overcurrent, thermal; fault is OR.
// - Duty level zero gives minimum output; 1 to 255 linear steps.
module sbr_port (
   input  wire logic                  CLK_SYS,
   input  wire logic                  SRST,
   input  wire logic                  SMB_CLK,
   input  wire logic                  SMB_DAT_I,
   output var  logic                  SMB_DAT_O,
   output var  logic                  SMB_DAT_OE,
   input  wire sbr_pkg::sbr_faults_t  FAULTS,
   input  wire logic                  BACKLIGHT_STATE,
   output var  logic [7:0]            PWM_DUTY_LEVEL,
   output var  logic                  PWM_MIN_OUTPUT,
   output var  logic [7:0]            DC_CURRENT_LEVEL,
   output var  logic [7:0]            CHANNEL_MASK,
   output var  logic                  SWITCH_RATE_SELECT,
   output var  logic [1:0]            SHORT_THRESHOLD_SELECT,
   output var  logic                  BACKLIGHT_ON,
   output var  logic                  PWM_UPDATE_STYLE,
   output var  logic                  EXT_SOURCE_SELECT,
   output var  sbr_pkg::sbr_dim_mode_t DIM_MODE
);
   import sbr_pkg::*;

   // ****************************************************************
   // Link side: the bus clock is the host's SCL, sampled at CLK_SYS
   // ****************************************************************
   // SCL only runs during frames and START/STOP are data edges while SCL
   // is high, so the protocol engine samples SCL/SDA at the system clock
   // after two flops; at 250 MHz a 30 ns bus clock gives ample margin.
   logic [1:0] pins_n;
   logic [1:0] pins_s;
   logic       scl_q_r;
   logic       sda_q_r;
   logic [4:0] levels_s;

   // Pins pass inverted so the zero reset of the flops equals the idle-high bus;
   // this keeps a false SCL edge out of the first cycles after reset
   sbr_sync #(.WIDTH(2)) u_sync (
      .CLK  (CLK_SYS),
      .SRST (SRST),
      .D    (~{SMB_CLK, SMB_DAT_I}),
      .Q    (pins_n)
   );
   assign pins_s = ~pins_n;

   // Fault and backlight levels come from the analog side
   sbr_sync #(.WIDTH(5)) u_sync_lvl (
      .CLK  (CLK_SYS),
      .SRST (SRST),
      .D    ({FAULTS, BACKLIGHT_STATE}),
      .Q    (levels_s)
   );

   // Previous sampled levels for edge detection
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= pins_s[1];
         sda_q_r <= pins_s[0];
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   assign scl_rise  = pins_s[1] & ~scl_q_r;
   assign scl_fall  = ~pins_s[1] & scl_q_r;
   assign start_det = pins_s[1] & scl_q_r & sda_q_r & ~pins_s[0];
   assign stop_det  = pins_s[1] & scl_q_r & ~sda_q_r & pins_s[0];

   // ****************************************************************
   // Protocol engine
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_CMD,
      ST_WDATA,
      ST_RDATA,
      ST_RACK
   } sbr_state_t;

   sbr_state_t state_r;
   logic [7:0] shift_r;
   logic [3:0] bit_cnt_r;
   logic       ack_phase_r;
   logic       have_cmd_r;
   logic [7:0] cmd_r;
   logic [7:0] tx_r;
   logic       drive_r;
   logic       drive_val_r;
   logic       wr_stb_r;
   sbr_wr_t    wr_r;
   logic [7:0] rd_data;

   // Address match: class nibble, bit 3 set, direction in bit 0
   function automatic logic addr_match(input logic [7:0] a);
      addr_match = (a[7:4] == `SBR_ADDR_CLASS)
                 & a[`SBR_ADDR_BIT3]
                 & (a[2:1] == 2'b00);
   endfunction

   // Byte collection on SCL rising edges, MSB first
   always_ff @(posedge CLK_SYS) begin
      if (SRST || start_det) begin
         shift_r <= 8'h00;
      end else if (scl_rise && !ack_phase_r) begin
         shift_r <= {shift_r[6:0], pins_s[0]};
      end
   end

   // Transaction sequencing; byte ends at the eighth clock, the ninth is the acknowledge
   always_ff @(posedge CLK_SYS) begin
      if (SRST || stop_det) begin
         state_r     <= ST_IDLE;
         bit_cnt_r   <= 4'h0;
         ack_phase_r <= 1'b0;
         have_cmd_r  <= 1'b0;
         cmd_r       <= 8'h00;
         wr_stb_r    <= 1'b0;
         wr_r        <= '0;
      end else if (start_det) begin
         // Repeated START keeps the command for the read turnaround
         state_r     <= ST_ADDR;
         bit_cnt_r   <= 4'h0;
         ack_phase_r <= 1'b0;
         wr_stb_r    <= 1'b0;
      end else begin
         wr_stb_r <= 1'b0;
         if (scl_rise && ack_phase_r) begin
            // Host ACK/NACK after a returned byte
            if (state_r == ST_RACK) begin
               state_r <= pins_s[0] ? ST_IDLE : ST_RDATA;
            end
         end else if (scl_rise && state_r != ST_IDLE) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
         end
         if (scl_fall && ack_phase_r) begin
            ack_phase_r <= 1'b0;
            bit_cnt_r   <= 4'h0;
         end else if (scl_fall && bit_cnt_r == 4'h8) begin
            ack_phase_r <= 1'b1;
            case (state_r)
               ST_ADDR: begin
                  if (addr_match(shift_r) && !shift_r[0]) begin
                     state_r  <= ST_CMD;
                  end else if (addr_match(shift_r) && have_cmd_r) begin
                     state_r  <= ST_RDATA;
                  end else begin
                     state_r  <= ST_IDLE;
                  end
               end
               ST_CMD: begin
                  cmd_r      <= shift_r;
                  have_cmd_r <= 1'b1;
                  state_r    <= ST_WDATA;
               end
               ST_WDATA: begin
                  // One data byte per write; extra bytes are refused
                  wr_r     <= '{addr: cmd_r, data: shift_r};
                  wr_stb_r <= 1'b1;
                  state_r  <= ST_IDLE;
               end
               ST_RDATA: begin
                  state_r <= ST_RACK;
               end
               default: begin
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Read byte latched when the read address is acknowledged
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         tx_r <= 8'h00;
      end else if (state_r == ST_RDATA && ack_phase_r && scl_fall) begin
         tx_r <= rd_data;
      end else if (state_r == ST_RDATA && scl_fall && bit_cnt_r != 4'h0) begin
         tx_r <= {tx_r[6:0], 1'b0};
      end
   end

   // Open-drain data drive: low for ACK, data bits while reading
   always_ff @(posedge CLK_SYS) begin
      if (SRST || stop_det || start_det) begin
         drive_r     <= 1'b0;
         drive_val_r <= 1'b1;
      end else if (scl_fall) begin
         if (bit_cnt_r == 4'h8 && state_r != ST_RDATA && !ack_phase_r) begin
            // Read address without a command earlier in the frame is refused
            drive_r     <= (addr_match(shift_r) && (!shift_r[0] || have_cmd_r))
                           || state_r != ST_ADDR;
            drive_val_r <= 1'b0;
         end else if (state_r == ST_RDATA && ack_phase_r) begin
            drive_r     <= ~rd_data[7];
            drive_val_r <= 1'b0;
         end else if (state_r == ST_RDATA && bit_cnt_r < 4'h8 && bit_cnt_r != 4'h0) begin
            drive_r     <= ~tx_r[6];
            drive_val_r <= 1'b0;
         end else begin
            drive_r     <= 1'b0;
            drive_val_r <= 1'b1;
         end
      end
   end

   assign SMB_DAT_O  = drive_val_r;
   assign SMB_DAT_OE = drive_r;

   // ****************************************************************
   // Register bank
   // ****************************************************************
   logic [7:0] pwm_r;
   logic [7:0] ctrl_r;
   logic [7:0] dc_r;
   logic [7:0] cfg_r;
   logic [7:0] mask_r;
   logic [7:0] status;

   // Only listed writable indices take a write; others are dropped
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         pwm_r  <= `SBR_RST_PWM;
         ctrl_r <= `SBR_RST_CTRL;
         dc_r   <= `SBR_RST_DC;
         cfg_r  <= `SBR_RST_CFG;
         mask_r <= `SBR_RST_MASK;
      end else if (wr_stb_r) begin
         if (wr_r.addr == `SBR_OFS_PWM) begin
            pwm_r <= wr_r.data;
         end else if (wr_r.addr == `SBR_OFS_CTRL) begin
            ctrl_r <= wr_r.data & `SBR_CTRL_MASK;
         end else if (wr_r.addr == `SBR_OFS_DC) begin
            dc_r <= wr_r.data;
         end else if (wr_r.addr == `SBR_OFS_CFG) begin
            cfg_r <= wr_r.data & `SBR_CFG_MASK;
         end else if (wr_r.addr == `SBR_OFS_MASK) begin
            mask_r <= wr_r.data;
         end
         // Status, identification and unlisted: no change
      end
   end

   // Status byte built live from the synchronised fault levels
   assign status = {2'b00, levels_s[4], levels_s[3], levels_s[0], levels_s[2], levels_s[1],
                    |levels_s[4:1]};

   // Read decode; unlisted indices read as zero
   always_comb begin
      if (cmd_r == `SBR_OFS_PWM) begin
         rd_data = pwm_r;
      end else if (cmd_r == `SBR_OFS_CTRL) begin
         rd_data = ctrl_r;
      end else if (cmd_r == `SBR_OFS_FAULT) begin
         rd_data = status;
      end else if (cmd_r == `SBR_OFS_ID) begin
         rd_data = `SBR_ID_VALUE; // Arbitrary neutral identity
      end else if (cmd_r == `SBR_OFS_DC) begin
         rd_data = dc_r;
      end else if (cmd_r == `SBR_OFS_CFG) begin
         rd_data = cfg_r;
      end else if (cmd_r == `SBR_OFS_MASK) begin
         rd_data = mask_r;
      end else begin
         rd_data = 8'h00;
      end
   end

   // ****************************************************************
   // Control outputs
   // ****************************************************************
   assign PWM_DUTY_LEVEL         = pwm_r;
   assign PWM_MIN_OUTPUT         = (pwm_r == 8'h00);
   assign DC_CURRENT_LEVEL       = dc_r;
   assign CHANNEL_MASK           = mask_r;
   assign SWITCH_RATE_SELECT     = cfg_r[2];
   assign SHORT_THRESHOLD_SELECT = cfg_r[1:0];
   assign BACKLIGHT_ON           = ctrl_r[`SBR_BIT_BL_ON];
   assign PWM_UPDATE_STYLE       = ctrl_r[`SBR_BIT_UPD_STYLE];
   assign EXT_SOURCE_SELECT      = ctrl_r[`SBR_BIT_SRC_SEL];

   // Source select overrides update style
   always_comb begin
      if (ctrl_r[`SBR_BIT_SRC_SEL]) begin
         DIM_MODE = SBR_DIM_EXT;
      end else if (ctrl_r[`SBR_BIT_UPD_STYLE]) begin
         DIM_MODE = SBR_DIM_BUS;
      end else begin
         DIM_MODE = SBR_DIM_COMBINED;
      end
   end
endmodule // sbr_port
`default_nettype wire

// ---- verification/sbr_host_model.sv ----
// Host master model of the bus: open-drain data line, bus clock idle high
`timescale 1ns/100ps
`default_nettype none
module sbr_host_model (
   output var logic scl,
   output var logic sda_oe,
   input  wire logic sda
);
   // ****************
   // Bit timing: 30 ns bit, 20 ns low, 10 ns high
   // ****************
   // Clock stands high and data released outside frames
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // Long low phase lets the device drop its drive before the next rise
   task automatic bit_io(input logic b, output logic r);
      #10 sda_oe = ~b;
      #10 scl = 1'b1;
      #5 r = sda;
      #5 scl = 1'b0;
   endtask
   task automatic start();
      #10 sda_oe = 1'b1;
      #10 scl = 1'b0;
   endtask
   task automatic rstart();
      #10 sda_oe = 1'b0;
      #10 scl = 1'b1;
      #10 sda_oe = 1'b1;
      #10 scl = 1'b0;
   endtask
   task automatic stop();
      #10 sda_oe = 1'b1;
      #10 scl = 1'b1;
      #10 sda_oe = 1'b0;
      #10;
   endtask
   // Byte out MSB first, then sample the acknowledge
   task automatic tx(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // Byte in, closed by a not-acknowledge unless more bytes are wanted
   task automatic rx(output logic [7:0] d, input logic more = 1'b0);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(~more, r);
   endtask
endmodule // sbr_host_model
`default_nettype wire

// ---- verification/sbr_port_monitor.sv ----
// Checker of the backlight register port
`timescale 1ns/100ps
`default_nettype none
module sbr_port_monitor (
   input wire logic                   CLK_SYS,
   input wire logic                   SRST,
   input wire logic                   SMB_CLK,
   input wire logic                   SMB_DAT_O,
   input wire logic                   SMB_DAT_OE,
   input wire logic [7:0]             PWM_DUTY_LEVEL,
   input wire logic                   PWM_MIN_OUTPUT,
   input wire logic [7:0]             DC_CURRENT_LEVEL,
   input wire logic [7:0]             CHANNEL_MASK,
   input wire logic [1:0]             SHORT_THRESHOLD_SELECT,
   input wire logic                   BACKLIGHT_ON,
   input wire logic                   PWM_UPDATE_STYLE,
   input wire logic                   EXT_SOURCE_SELECT,
   input wire sbr_pkg::sbr_dim_mode_t DIM_MODE
);
   import sbr_pkg::*;
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   sequence s_scl_high; SMB_CLK [*3]; endsequence
   sequence s_mode_held; $stable({PWM_UPDATE_STYLE, EXT_SOURCE_SELECT}) [*2]; endsequence
   property p_dat_low; SMB_DAT_OE |-> !SMB_DAT_O; endproperty
   property p_oe_reset; $past(SRST) |-> !SMB_DAT_OE; endproperty
   property p_regs_reset;
      $past(SRST) |-> PWM_DUTY_LEVEL == 8'hFF && DC_CURRENT_LEVEL == 8'hFF
         && CHANNEL_MASK == 8'hFF && SHORT_THRESHOLD_SELECT == 2'h3 && !BACKLIGHT_ON
         && !EXT_SOURCE_SELECT && !PWM_UPDATE_STYLE;
   endproperty
   // Drive only changes while the bus clock is low
   property p_oe_hold; s_scl_high |-> $stable(SMB_DAT_OE); endproperty
   property p_min_out;
      $stable(PWM_DUTY_LEVEL) |-> PWM_MIN_OUTPUT == (PWM_DUTY_LEVEL == 8'h00);
   endproperty
   property p_mode_ext; s_mode_held ##0 EXT_SOURCE_SELECT |-> DIM_MODE == SBR_DIM_EXT; endproperty
   property p_mode_bus;
      s_mode_held ##0 (!EXT_SOURCE_SELECT && PWM_UPDATE_STYLE) |-> DIM_MODE == SBR_DIM_BUS;
   endproperty
   property p_mode_comb;
      s_mode_held ##0 !(EXT_SOURCE_SELECT || PWM_UPDATE_STYLE) |-> DIM_MODE == SBR_DIM_COMBINED;
   endproperty
   a_dat_low: assert property (p_dat_low) else $error("data driven high");
   a_oe_reset: assert property (p_oe_reset) else $error("drive after reset");
   a_regs_reset: assert property (p_regs_reset) else $error("bad reset value");
   a_oe_hold: assert property (p_oe_hold) else $error("drive moved in high");
   a_min_out: assert property (p_min_out) else $error("min output wrong");
   a_mode_ext: assert property (p_mode_ext) else $error("ext mode wrong");
   a_mode_bus: assert property (p_mode_bus) else $error("bus mode wrong");
   a_mode_comb: assert property (p_mode_comb) else $error("combined mode wrong");
endmodule // sbr_port_monitor
bind sbr_port sbr_port_monitor i_mon (.CLK_SYS(CLK_SYS), .SRST(SRST), .SMB_CLK(SMB_CLK),
   .SMB_DAT_O(SMB_DAT_O), .SMB_DAT_OE(SMB_DAT_OE), .PWM_DUTY_LEVEL(PWM_DUTY_LEVEL),
   .PWM_MIN_OUTPUT(PWM_MIN_OUTPUT), .DC_CURRENT_LEVEL(DC_CURRENT_LEVEL),
   .CHANNEL_MASK(CHANNEL_MASK), .SHORT_THRESHOLD_SELECT(SHORT_THRESHOLD_SELECT),
   .BACKLIGHT_ON(BACKLIGHT_ON), .PWM_UPDATE_STYLE(PWM_UPDATE_STYLE),
   .EXT_SOURCE_SELECT(EXT_SOURCE_SELECT), .DIM_MODE(DIM_MODE));
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench of the backlight register port
`timescale 1ns/100ps
`default_nettype none
`include "sbr_cfg.svh"
module tb_top;
   import sbr_pkg::*;
   logic clk, srst, scl, h_oe, d_o, d_oe, sda, bls, pmin, swr, bon, upd, ext;
   logic [7:0] pwm, dcl, msk;
   logic [1:0] sth;
   sbr_faults_t flt;
   sbr_dim_mode_t dm;
   int miscompares, checks_done;
   int cycles = 0;
   assign sda = ~(h_oe | d_oe); // Pull-up wire
   sbr_port i_dut (.CLK_SYS(clk), .SRST(srst), .SMB_CLK(scl), .SMB_DAT_I(sda),
      .SMB_DAT_O(d_o), .SMB_DAT_OE(d_oe), .FAULTS(flt), .BACKLIGHT_STATE(bls),
      .PWM_DUTY_LEVEL(pwm), .PWM_MIN_OUTPUT(pmin), .DC_CURRENT_LEVEL(dcl),
      .CHANNEL_MASK(msk), .SWITCH_RATE_SELECT(swr), .SHORT_THRESHOLD_SELECT(sth),
      .BACKLIGHT_ON(bon), .PWM_UPDATE_STYLE(upd), .EXT_SOURCE_SELECT(ext), .DIM_MODE(dm));
   sbr_host_model i_host (.scl(scl), .sda_oe(h_oe), .sda(sda));
   // ****************
   // Helpers
   // ****************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Write frame; every byte must be acknowledged
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      logic [2:0] k;
      i_host.start();
      i_host.tx(`SBR_ADDR_WR, k[2]);
      i_host.tx(c, k[1]);
      i_host.tx(d, k[0]);
      i_host.stop();
      chk({5'h0, k}, 8'h07);
      repeat (8) @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] c, input logic [7:0] e);
      logic [2:0] k;
      logic [7:0] d;
      i_host.start();
      i_host.tx(`SBR_ADDR_WR, k[2]);
      i_host.tx(c, k[1]);
      i_host.rstart();
      i_host.tx(`SBR_ADDR_RD, k[0]);
      i_host.rx(d);
      i_host.stop();
      chk({5'h0, k}, 8'h07);
      chk(d, e);
   endtask
   task automatic complete_run();
      if (miscompares == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      rd(`SBR_OFS_PWM, 8'hFF);
      rd(`SBR_OFS_CTRL, 8'h00);
      rd(`SBR_OFS_DC, 8'hFF);
      rd(`SBR_OFS_CFG, `SBR_RST_CFG);
      rd(`SBR_OFS_MASK, 8'hFF);
   endtask
   task automatic t_rw();
      wr(`SBR_OFS_PWM, 8'h00);
      chk({7'h0, pmin}, 8'h01);
      wr(`SBR_OFS_DC, 8'h5A);
      wr(`SBR_OFS_CFG, 8'hFE);
      wr(`SBR_OFS_MASK, 8'h3C);
      rd(`SBR_OFS_CFG, 8'h06);
      chk({dcl[3:0], msk[3:0]}, 8'hAC);
      chk({5'h0, swr, sth}, 8'h06);
      wr(`SBR_OFS_PWM, 8'h01);
      chk({pwm[6:0], pmin}, 8'h02);
   endtask
   task automatic t_modes();
      sbr_dim_mode_t m;
      for (int v = 0; v < 8; v++) begin
         wr(`SBR_OFS_CTRL, 8'hF8 | 8'(v));
         m = v[1] ? SBR_DIM_EXT : (v[2] ? SBR_DIM_BUS : SBR_DIM_COMBINED);
         chk({5'h0, upd, ext, bon}, 8'(v));
         chk({6'h0, dm}, {6'h0, m});
      end
      rd(`SBR_OFS_CTRL, 8'h07);
   endtask
   task automatic t_ro();
      wr(`SBR_OFS_FAULT, 8'hFF);
      wr(`SBR_OFS_ID, 8'h00);
      wr(8'h05, 8'hFF);
      rd(8'h05, 8'h00);
      rd(`SBR_OFS_ID, `SBR_ID_VALUE);
      rd(`SBR_OFS_FAULT, 8'h00);
      rd(`SBR_OFS_DC, 8'h5A);
   endtask
   task automatic t_addr();
      logic [7:0] a[4] = '{8'h50, 8'h78, 8'hD8, `SBR_ADDR_RD};
      logic k;
      foreach (a[i]) begin
         i_host.start();
         i_host.tx(a[i], k);
         i_host.stop();
         chk({7'h0, k}, 8'h00);
      end
   endtask
   // Fault inputs, backlight state, expected status byte
   task automatic t_status();
      logic [12:0] v[3] = '{13'h152D, 13'h0203, 13'h0811};
      foreach (v[i]) begin
         @(posedge clk);
         #1 {flt, bls} = v[i][12:8];
         rd(`SBR_OFS_FAULT, v[i][7:0]);
      end
   endtask
   // Host acknowledge after the data byte asks for the same index again
   task automatic t_burst();
      logic [7:0] d0;
      logic [7:0] d1;
      logic [2:0] k;
      i_host.start();
      i_host.tx(`SBR_ADDR_WR, k[2]);
      i_host.tx(`SBR_OFS_DC, k[1]);
      i_host.rstart();
      i_host.tx(`SBR_ADDR_RD, k[0]);
      i_host.rx(d0, 1'b1);
      i_host.rx(d1);
      i_host.stop();
      chk({5'h0, k}, 8'h07);
      chk(d0, 8'h5A);
      chk(d1, 8'h5A);
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Hang guard: far above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      srst = 1'b1;
      flt = '0;
      bls = 1'b0;
      miscompares = 0;
      checks_done = 0;
      repeat (2) @(posedge clk);
      #1 srst = 1'b0;
      repeat (4) @(posedge clk);
      t_reset();
      t_rw();
      t_modes();
      t_ro();
      t_addr();
      t_status();
      t_burst();
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
